// [uhr_reg_bank.sv]
`default_nettype none
module uhr_reg_bank #(
  // Arbitrary neutral values; the real part supplies its own.
  parameter logic [7:0] REVISION_BCD = 8'h20,
  parameter logic [15:0] PART_ID = 16'h5A01
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [31:0] i_cmd_wdata,
  input wire logic [31:0] i_evt_set,
  input wire logic [15:0] i_cpu_evt_set,
  input wire logic i_resume_detect,
  input wire logic [31:0] i_frame_remain,
  input wire logic [31:0] i_frame_number,
  input wire logic [15:0] i_buf_status,
  input wire logic [15:0] i_iso_rb0_len,
  input wire logic [15:0] i_iso_rb1_len,
  input wire logic [15:0] i_buf_rdata,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  output logic o_cmd_bad,
  output logic o_buf_rd,
  output logic o_buf_wr,
  output logic o_buf_async,
  output logic [15:0] o_buf_wdata,
  output logic o_soft_reset,
  output logic [31:0] o_mode_ctrl,
  output logic [31:0] o_evt_status,
  output logic [31:0] o_evt_enable,
  output logic [15:0] o_hw_setup,
  output logic [15:0] o_dma_setup,
  output logic [15:0] o_cpu_evt_flags,
  output logic [15:0] o_cpu_evt_mask,
  output logic [15:0] o_iso_len,
  output logic [15:0] o_async_len,
  output logic [31:0] o_frame_interval,
  output logic [31:0] o_slow_threshold
);

  ////////////////////////////////////////////////////////////////////////////
  logic wr;
  logic rd;
  logic [7:0] code;
  logic soft_rst;
  logic [31:0] mode_ctrl_reg;
  logic [31:0] cmd_status_reg;
  logic [31:0] evt_status_reg;
  logic [31:0] evt_enable_reg;
  logic [31:0] frame_interval_reg;
  logic [31:0] slow_threshold_reg;
  logic [31:0] hub_desc_a_reg;
  logic [31:0] hub_desc_b_reg;
  logic [31:0] hub_status_reg;
  logic [31:0] port_one_reg;
  logic [31:0] port_two_reg;
  logic [15:0] hw_setup_reg;
  logic [15:0] dma_setup_reg;
  logic [15:0] xfer_count_reg;
  logic [15:0] cpu_flags_reg;
  logic [15:0] cpu_mask_reg;
  logic [15:0] scratch_reg;
  logic [15:0] iso_len_reg;
  logic [15:0] async_len_reg;
  logic [31:0] rd_data_next;
  logic hit;

  // Codes with bit 7 set are writes, the rest reads.
  assign wr = i_cmd_valid && i_cmd_code[7];
  assign rd = i_cmd_valid && !i_cmd_code[7];
  assign code = i_cmd_code & ~uhr_pkg::WR_FLAG;
  assign soft_rst = wr && (i_cmd_code == uhr_pkg::C_SOFT_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // Operating-mode control. Software reset returns the state to reset but
  // keeps the wake-connected bit, which a hardware reset clears and a mode-control write loads from the data.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_ctrl_reg <= uhr_pkg::RST32;
    end else if (soft_rst) begin
      mode_ctrl_reg <= uhr_pkg::RST32;
      mode_ctrl_reg[uhr_pkg::WAKE_CONN_BIT] <= mode_ctrl_reg[uhr_pkg::WAKE_CONN_BIT];
    end else if (wr && code == uhr_pkg::C_MODE_CTRL) begin
      mode_ctrl_reg <= i_cmd_wdata;
    end else if (i_resume_detect &&
                 mode_ctrl_reg[uhr_pkg::STATE_LSB+:2] == uhr_pkg::ST_SUSPEND) begin
      // Hardware only moves the state out of suspend; wake enable is untouched.
      mode_ctrl_reg[uhr_pkg::STATE_LSB+:2] <= uhr_pkg::ST_RESUME;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status clears by writing ones; a new event in the same cycle wins.
  always_ff @(posedge i_clk) begin
    if (i_rst || soft_rst) begin
      evt_status_reg <= uhr_pkg::RST32;
    end else if (wr && code == uhr_pkg::C_EVT_STATUS) begin
      evt_status_reg <= (evt_status_reg & ~i_cmd_wdata) | i_evt_set;
    end else begin
      evt_status_reg <= evt_status_reg | i_evt_set;
    end
  end

  // One enable register behind two write codes: set and clear.
  always_ff @(posedge i_clk) begin
    if (i_rst || soft_rst) begin
      evt_enable_reg <= uhr_pkg::RST32;
    end else if (wr && code == uhr_pkg::C_EVT_EN_SET) begin
      evt_enable_reg <= evt_enable_reg | i_cmd_wdata;
    end else if (wr && code == uhr_pkg::C_EVT_EN_CLR) begin
      evt_enable_reg <= evt_enable_reg & ~i_cmd_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || soft_rst) begin
      cpu_flags_reg <= uhr_pkg::RST16;
    end else if (wr && code == uhr_pkg::C_CPU_FLAGS) begin
      cpu_flags_reg <= (cpu_flags_reg & ~i_cmd_wdata[15:0]) | i_cpu_evt_set;
    end else begin
      cpu_flags_reg <= cpu_flags_reg | i_cpu_evt_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain read/write storage.
  always_ff @(posedge i_clk) begin
    if (i_rst || soft_rst) begin
      cmd_status_reg <= uhr_pkg::RST32;
      frame_interval_reg <= uhr_pkg::RST32;
      slow_threshold_reg <= uhr_pkg::RST32;
      hub_desc_a_reg <= uhr_pkg::RST32;
      hub_desc_b_reg <= uhr_pkg::RST32;
      hub_status_reg <= uhr_pkg::RST32;
      port_one_reg <= uhr_pkg::RST32;
      port_two_reg <= uhr_pkg::RST32;
      hw_setup_reg <= uhr_pkg::RST16;
      dma_setup_reg <= uhr_pkg::RST16;
      xfer_count_reg <= uhr_pkg::RST16;
      cpu_mask_reg <= uhr_pkg::RST16;
      iso_len_reg <= uhr_pkg::RST16;
      async_len_reg <= uhr_pkg::RST16;
    end else if (wr) begin
      unique case (code)
        uhr_pkg::C_CMD_STATUS: cmd_status_reg <= i_cmd_wdata;
        uhr_pkg::C_FRAME_INTERVAL: frame_interval_reg <= i_cmd_wdata;
        uhr_pkg::C_SLOW_THRESHOLD: slow_threshold_reg <= i_cmd_wdata;
        uhr_pkg::C_HUB_DESC_A: hub_desc_a_reg <= i_cmd_wdata;
        uhr_pkg::C_HUB_DESC_B: hub_desc_b_reg <= i_cmd_wdata;
        uhr_pkg::C_HUB_STATUS: hub_status_reg <= i_cmd_wdata;
        uhr_pkg::C_PORT_ONE: port_one_reg <= i_cmd_wdata;
        uhr_pkg::C_PORT_TWO: port_two_reg <= i_cmd_wdata;
        uhr_pkg::C_HW_SETUP: hw_setup_reg <= i_cmd_wdata[15:0];
        uhr_pkg::C_DMA_SETUP: dma_setup_reg <= i_cmd_wdata[15:0];
        uhr_pkg::C_XFER_COUNT: xfer_count_reg <= i_cmd_wdata[15:0];
        uhr_pkg::C_CPU_MASK: cpu_mask_reg <= i_cmd_wdata[15:0];
        uhr_pkg::C_ISO_LEN: iso_len_reg <= i_cmd_wdata[15:0];
        uhr_pkg::C_ASYNC_LEN: async_len_reg <= i_cmd_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Scratch survives a software reset so software can test it afterwards.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scratch_reg <= uhr_pkg::RST16;
    end else if (wr && code == uhr_pkg::C_SCRATCH) begin
      scratch_reg <= i_cmd_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; hit also covers legal write codes for the error flag.
  always_comb begin
    rd_data_next = uhr_pkg::RST32;
    hit = 1'b1;
    if (rd) begin
      unique case (code)
        uhr_pkg::C_REVISION: rd_data_next = {24'h000000, REVISION_BCD};
        uhr_pkg::C_MODE_CTRL: rd_data_next = mode_ctrl_reg;
        uhr_pkg::C_CMD_STATUS: rd_data_next = cmd_status_reg;
        uhr_pkg::C_EVT_STATUS: rd_data_next = evt_status_reg;
        uhr_pkg::C_EVT_EN_SET: rd_data_next = evt_enable_reg;
        uhr_pkg::C_EVT_EN_CLR: rd_data_next = evt_enable_reg;
        uhr_pkg::C_FRAME_INTERVAL: rd_data_next = frame_interval_reg;
        uhr_pkg::C_FRAME_REMAIN: rd_data_next = i_frame_remain;
        uhr_pkg::C_FRAME_NUMBER: rd_data_next = i_frame_number;
        uhr_pkg::C_SLOW_THRESHOLD: rd_data_next = slow_threshold_reg;
        uhr_pkg::C_HUB_DESC_A: rd_data_next = hub_desc_a_reg;
        uhr_pkg::C_HUB_DESC_B: rd_data_next = hub_desc_b_reg;
        uhr_pkg::C_HUB_STATUS: rd_data_next = hub_status_reg;
        uhr_pkg::C_PORT_ONE: rd_data_next = port_one_reg;
        uhr_pkg::C_PORT_TWO: rd_data_next = port_two_reg;
        uhr_pkg::C_HW_SETUP: rd_data_next = {16'h0000, hw_setup_reg};
        uhr_pkg::C_DMA_SETUP: rd_data_next = {16'h0000, dma_setup_reg};
        uhr_pkg::C_XFER_COUNT: rd_data_next = {16'h0000, xfer_count_reg};
        uhr_pkg::C_CPU_FLAGS: rd_data_next = {16'h0000, cpu_flags_reg};
        uhr_pkg::C_CPU_MASK: rd_data_next = {16'h0000, cpu_mask_reg};
        uhr_pkg::C_PART_ID: rd_data_next = {16'h0000, PART_ID};
        uhr_pkg::C_SCRATCH: rd_data_next = {16'h0000, scratch_reg};
        uhr_pkg::C_ISO_LEN: rd_data_next = {16'h0000, iso_len_reg};
        uhr_pkg::C_ASYNC_LEN: rd_data_next = {16'h0000, async_len_reg};
        uhr_pkg::C_BUF_STATUS: rd_data_next = {16'h0000, i_buf_status};
        uhr_pkg::C_ISO_RB0: rd_data_next = {16'h0000, i_iso_rb0_len};
        uhr_pkg::C_ISO_RB1: rd_data_next = {16'h0000, i_iso_rb1_len};
        uhr_pkg::C_ISO_PORT: rd_data_next = {16'h0000, i_buf_rdata};
        uhr_pkg::C_ASYNC_PORT: rd_data_next = {16'h0000, i_buf_rdata};
        default: hit = 1'b0;
      endcase
    end else if (wr) begin
      // Read-only registers have no write code, so these fall out as errors.
      unique case (code)
        uhr_pkg::C_MODE_CTRL, uhr_pkg::C_CMD_STATUS, uhr_pkg::C_EVT_STATUS,
        uhr_pkg::C_EVT_EN_SET, uhr_pkg::C_EVT_EN_CLR, uhr_pkg::C_FRAME_INTERVAL,
        uhr_pkg::C_SLOW_THRESHOLD, uhr_pkg::C_HUB_DESC_A, uhr_pkg::C_HUB_DESC_B,
        uhr_pkg::C_HUB_STATUS, uhr_pkg::C_PORT_ONE, uhr_pkg::C_PORT_TWO,
        uhr_pkg::C_HW_SETUP, uhr_pkg::C_DMA_SETUP, uhr_pkg::C_XFER_COUNT,
        uhr_pkg::C_CPU_FLAGS, uhr_pkg::C_CPU_MASK, uhr_pkg::C_SCRATCH,
        uhr_pkg::C_ISO_LEN, uhr_pkg::C_ASYNC_LEN, uhr_pkg::C_ISO_PORT,
        uhr_pkg::C_ASYNC_PORT: hit = 1'b1;
        default: hit = (i_cmd_code == uhr_pkg::C_SOFT_RESET);
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= uhr_pkg::RST32;
      o_cmd_bad <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_rd_valid <= rd && hit;
      o_rd_data <= rd_data_next;
      o_cmd_bad <= i_cmd_valid && !hit;
      o_soft_reset <= soft_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer ports are strobes into the buffer RAM; the read strobe is
  // combinational so the RAM word is caught with the read answer.
  assign o_buf_rd = rd && (code == uhr_pkg::C_ISO_PORT || code == uhr_pkg::C_ASYNC_PORT);
  assign o_buf_async = (code == uhr_pkg::C_ASYNC_PORT);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_buf_wr <= 1'b0;
      o_buf_wdata <= uhr_pkg::RST16;
    end else begin
      o_buf_wr <= wr && (code == uhr_pkg::C_ISO_PORT || code == uhr_pkg::C_ASYNC_PORT);
      o_buf_wdata <= i_cmd_wdata[15:0];
    end
  end

  assign o_mode_ctrl = mode_ctrl_reg;
  assign o_evt_status = evt_status_reg;
  assign o_evt_enable = evt_enable_reg;
  assign o_hw_setup = hw_setup_reg;
  assign o_dma_setup = dma_setup_reg;
  assign o_cpu_evt_flags = cpu_flags_reg;
  assign o_cpu_evt_mask = cpu_mask_reg;
  assign o_iso_len = iso_len_reg;
  assign o_async_len = async_len_reg;
  assign o_frame_interval = frame_interval_reg;
  assign o_slow_threshold = slow_threshold_reg;

endmodule // uhr_reg_bank
`default_nettype wire

// [uhr_pkg.sv]
`default_nettype none
package uhr_pkg;
  localparam logic [7:0] WR_FLAG = 8'h80;
  // Operational registers: read code equals OHCI byte offset divided by four.
  localparam logic [7:0] C_REVISION = 8'h00;
  localparam logic [7:0] C_MODE_CTRL = 8'h01;
  localparam logic [7:0] C_CMD_STATUS = 8'h02;
  localparam logic [7:0] C_EVT_STATUS = 8'h03;
  localparam logic [7:0] C_EVT_EN_SET = 8'h04;
  localparam logic [7:0] C_EVT_EN_CLR = 8'h05;
  localparam logic [7:0] C_FRAME_INTERVAL = 8'h0D;
  localparam logic [7:0] C_FRAME_REMAIN = 8'h0E;
  localparam logic [7:0] C_FRAME_NUMBER = 8'h0F;
  localparam logic [7:0] C_SLOW_THRESHOLD = 8'h11;
  localparam logic [7:0] C_HUB_DESC_A = 8'h12;
  localparam logic [7:0] C_HUB_DESC_B = 8'h13;
  localparam logic [7:0] C_HUB_STATUS = 8'h14;
  localparam logic [7:0] C_PORT_ONE = 8'h15;
  localparam logic [7:0] C_PORT_TWO = 8'h16;
  // Sixteen-bit registers.
  localparam logic [7:0] C_HW_SETUP = 8'h20;
  localparam logic [7:0] C_DMA_SETUP = 8'h21;
  localparam logic [7:0] C_XFER_COUNT = 8'h22;
  localparam logic [7:0] C_CPU_FLAGS = 8'h24;
  localparam logic [7:0] C_CPU_MASK = 8'h25;
  localparam logic [7:0] C_PART_ID = 8'h27;
  localparam logic [7:0] C_SCRATCH = 8'h28;
  localparam logic [7:0] C_SOFT_RESET = 8'hA9;
  localparam logic [7:0] C_ISO_LEN = 8'h2A;
  localparam logic [7:0] C_ASYNC_LEN = 8'h2B;
  localparam logic [7:0] C_BUF_STATUS = 8'h2C;
  localparam logic [7:0] C_ISO_RB0 = 8'h2D;
  localparam logic [7:0] C_ISO_RB1 = 8'h2E;
  localparam logic [7:0] C_ISO_PORT = 8'h40;
  localparam logic [7:0] C_ASYNC_PORT = 8'h41;
  // Field positions.
  localparam int REV_MSB = 7;
  localparam int WAKE_EN_BIT = 10;
  localparam int WAKE_CONN_BIT = 9;
  localparam int STATE_LSB = 6;
  // Functional states of the host controller.
  localparam logic [1:0] ST_RESET = 2'h0;
  localparam logic [1:0] ST_RESUME = 2'h1;
  localparam logic [1:0] ST_OPER = 2'h2;
  localparam logic [1:0] ST_SUSPEND = 2'h3;
  localparam logic [31:0] RST32 = 32'h0000_0000;
  localparam logic [15:0] RST16 = 16'h0000;
endpackage
`default_nettype wire

// [uhr_reg_bank_checker.sv]
`default_nettype none
module uhr_reg_bank_checker #(
  parameter logic [7:0] REVISION_BCD = 8'h20,
  parameter logic [15:0] PART_ID = 16'h5A01
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [31:0] i_cmd_wdata,
  input wire logic [15:0] i_buf_rdata,
  input wire logic o_rd_valid,
  input wire logic [31:0] o_rd_data,
  input wire logic o_cmd_bad,
  input wire logic o_buf_rd,
  input wire logic o_buf_async,
  input wire logic o_soft_reset,
  input wire logic [31:0] o_mode_ctrl,
  input wire logic [15:0] o_hw_setup
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Code FFh is never mapped, so it stands for an idle cycle.
  logic [7:0] c;
  logic sw_wr;
  assign c = i_cmd_valid ? i_cmd_code : 8'hFF;
  assign sw_wr = (c == 8'h81) || (c == 8'hA9);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_buf_req;
    o_buf_rd && !o_buf_async;
  endsequence
  sequence s_buf_ans;
    o_rd_valid && o_rd_data == {16'h0000, $past(i_buf_rdata)};
  endsequence
  a_rev_read_value: assert property (
    c == 8'h00 |=> o_rd_valid && o_rd_data == {24'h000000, REVISION_BCD}) else $error("bad rev");
  a_rev_no_write: assert property (
    c == 8'h80 |=> o_cmd_bad && !o_rd_valid && $stable(o_mode_ctrl)) else $error("rev written");
  a_mode_write: assert property (
    c == 8'h81 |=> o_mode_ctrl == $past(i_cmd_wdata)) else $error("mode write lost");
  a_wake_sw_only: assert property (
    $changed(o_mode_ctrl[uhr_pkg::WAKE_EN_BIT]) |-> $past(sw_wr))
    else $error("wake enable moved alone");
  a_opreg_read: assert property (
    c inside {[8'h00:8'h05], [8'h0D:8'h0F], [8'h11:8'h16]} |=> o_rd_valid && !o_cmd_bad)
    else $error("op read refused");
  a_ro_refused: assert property (
    c inside {8'h8E, 8'h8F, 8'hA7, [8'hAC:8'hAE]} |=> o_cmd_bad && !o_rd_valid)
    else $error("read-only write taken");
  a_write_taken: assert property (
    c inside {[8'h81:8'h85], 8'h8D, [8'h91:8'h96], [8'hA0:8'hA2], 8'hA4, 8'hA5, 8'hA8,
      8'hAA, 8'hAB, 8'hC0, 8'hC1} |=> !o_cmd_bad && !o_rd_valid) else $error("write refused");
  a_short_width: assert property (
    c inside {[8'h20:8'h22], 8'h24, 8'h25, 8'h27, 8'h28, [8'h2A:8'h2E]}
    |=> o_rd_valid && o_rd_data[31:16] == 16'h0000) else $error("short read wide");
  a_part_id: assert property (
    c == 8'h27 |=> o_rd_data == {16'h0000, PART_ID}) else $error("bad part id");
  a_soft_reset: assert property (
    c == 8'hA9 |=> o_soft_reset && o_hw_setup == 16'h0000) else $error("soft reset missed");
  a_buf_read: assert property (
    c == 8'h40 |-> s_buf_req ##1 s_buf_ans) else $error("buffer read wrong");
endmodule // uhr_reg_bank_checker
bind uhr_reg_bank uhr_reg_bank_checker #(.REVISION_BCD(REVISION_BCD), .PART_ID(PART_ID)) u_chk (
  .i_clk, .i_rst, .i_cmd_valid, .i_cmd_code, .i_cmd_wdata, .i_buf_rdata, .o_rd_valid,
  .o_rd_data, .o_cmd_bad, .o_buf_rd, .o_buf_async, .o_soft_reset, .o_mode_ctrl, .o_hw_setup);
`default_nettype wire

// [uhr_cpu_model.sv]
`default_nettype none
module uhr_cpu_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rd_data,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [31:0] o_cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_rd;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_wdata = 32'h0000_0000;
  end
  // Called at a falling edge; the answer is taken one cycle later.
  task automatic issue(input logic [7:0] code, input logic [31:0] data);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_wdata = data;
    @(negedge i_clk);
    last_rd = i_rd_data;
  endtask
  // Idle lines toggle so nothing can lean on a stale command.
  task automatic idle();
    o_cmd_valid = 1'b0;
    o_cmd_code = ~o_cmd_code;
    o_cmd_wdata = ~o_cmd_wdata;
    @(negedge i_clk);
  endtask
  task automatic rmw(input logic [7:0] rd, input logic [31:0] mask, input logic [31:0] val);
    issue(rd, 32'h0000_0000);
    issue(rd | 8'h80, (last_rd & ~mask) | (val & mask));
  endtask
  task automatic set_clear(input logic [7:0] wr, input logic [31:0] bits, input logic [31:0] defd);
    issue(wr, bits & defd);
  endtask
endmodule // uhr_cpu_model
`default_nettype wire

// [usb_host_register_map_test.sv]
`default_nettype none
module usb_host_register_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] w; logic [7:0] r; logic [31:0] d; logic [31:0] e;} uhr_row_s;
  // Arbitrary identity values.
  localparam logic [7:0] REV = 8'h20;
  localparam logic [15:0] PID = 16'h5A01;
  localparam uhr_row_s ROWS [19] = '{
    '{8'h81, 8'h01, 32'hA5A5_0480, 32'hA5A5_0480}, '{8'h8D, 8'h0D, 32'h2EDF_2EDF, 32'h2EDF_2EDF},
    '{8'h91, 8'h11, 32'h0000_0628, 32'h0000_0628}, '{8'h92, 8'h12, 32'h0100_0202, 32'h0100_0202},
    '{8'hA0, 8'h20, 32'hFFFF_1234, 32'h0000_1234}, '{8'hA1, 8'h21, 32'h0000_0ABC, 32'h0000_0ABC},
    '{8'hA2, 8'h22, 32'h0000_0040, 32'h0000_0040}, '{8'hA5, 8'h25, 32'h0000_00FF, 32'h0000_00FF},
    '{8'hA8, 8'h28, 32'h0000_BEEF, 32'h0000_BEEF}, '{8'hAA, 8'h2A, 32'h0000_0800, 32'h0000_0800},
    '{8'hAB, 8'h2B, 32'h0000_1000, 32'h0000_1000}, '{8'h00, 8'h0E, 32'h0, 32'h0000_2A10},
    '{8'h00, 8'h0F, 32'h0, 32'h0000_0123}, '{8'h00, 8'h2C, 32'h0, 32'h0000_0003},
    '{8'h00, 8'h2D, 32'h0, 32'h0000_0040}, '{8'h00, 8'h2E, 32'h0, 32'h0000_0080},
    '{8'h00, 8'h00, 32'h0, {24'h000000, REV}}, '{8'h00, 8'h27, 32'h0, {16'h0000, PID}},
    '{8'h00, 8'h40, 32'h0, 32'h0000_55AA}};
  localparam logic [7:0] ODD [10] = '{8'h80, 8'h8E, 8'h8F, 8'hA7, 8'hAC, 8'h30, 8'h93, 8'h94,
    8'h95, 8'h96};
  logic i_clk, i_rst, i_resume_detect, cv, rdv, bad, brd, bwr, basy, srst;
  logic [7:0] code;
  logic [31:0] wd, evt, frem, fnum, rdd, mode, est, een, fint, slow;
  logic [15:0] cevt, bst, rb0, rb1, bdat, bwd, hw, dma, cfl, cmk, il, al;
  int miscompares = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////
  uhr_reg_bank #(.REVISION_BCD(REV), .PART_ID(PID)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmd_valid(cv), .i_cmd_code(code), .i_cmd_wdata(wd), .i_evt_set(evt),
    .i_cpu_evt_set(cevt), .i_resume_detect(i_resume_detect), .i_frame_remain(frem),
    .i_frame_number(fnum), .i_buf_status(bst), .i_iso_rb0_len(rb0), .i_iso_rb1_len(rb1),
    .i_buf_rdata(bdat), .o_rd_valid(rdv), .o_rd_data(rdd), .o_cmd_bad(bad), .o_buf_rd(brd),
    .o_buf_wr(bwr), .o_buf_async(basy), .o_buf_wdata(bwd), .o_soft_reset(srst),
    .o_mode_ctrl(mode), .o_evt_status(est), .o_evt_enable(een), .o_hw_setup(hw),
    .o_dma_setup(dma), .o_cpu_evt_flags(cfl), .o_cpu_evt_mask(cmk), .o_iso_len(il),
    .o_async_len(al), .o_frame_interval(fint), .o_slow_threshold(slow));
  uhr_cpu_model cpu (.i_clk(i_clk), .i_rd_data(rdd), .o_cmd_valid(cv), .o_cmd_code(code),
    .o_cmd_wdata(wd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always #2 i_clk = ~i_clk;
  // The whole run is 74 cycles (296 ns); this bound is 2000 cycles, about 27 times that.
  initial begin
    #8000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {i_clk, i_rst, i_resume_detect, evt, cevt} = {3'b010, 48'h0};
    {frem, fnum, bst, rb0, rb1, bdat} = {32'h2A10, 32'h0123, 16'h3, 16'h40, 16'h80, 16'h55AA};
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    cpu.issue(8'h01, 32'h0);
    chk32(rdd, 32'h0);
    chk32(mode | est | een, 32'h0);
    foreach (ROWS[i]) begin
      if (ROWS[i].w[7]) begin
        cpu.issue(ROWS[i].w, ROWS[i].d);
        chk1(bad, 1'b0);
      end
      cpu.issue(ROWS[i].r, ~ROWS[i].d);
      chk1(rdv, 1'b1);
      chk32(rdd, ROWS[i].e);
    end
    foreach (ODD[i]) begin
      cpu.issue(ODD[i], 32'hFFFF_FFFF);
      chk1(bad, i < 6);
    end
    cpu.rmw(8'h01, 32'h0000_06C0, 32'h0000_06C0);
    chk32(mode, 32'hA5A5_06C0);
    cpu.idle();
    i_resume_detect = 1'b1;
    @(negedge i_clk);
    i_resume_detect = 1'b0;
    @(negedge i_clk);
    chk32(mode, 32'hA5A5_0640);
    cpu.set_clear(8'h84, 32'hFFFF_FFFF, 32'hC000_007F);
    cpu.set_clear(8'h85, 32'h0000_0001, 32'hC000_007F);
    chk32(een, 32'hC000_007E);
    cpu.issue(8'hA9, 32'h0);
    chk1(srst, 1'b1);
    chk32(mode, 32'h0000_0200);
    cpu.issue(8'h28, 32'h0);
    chk1(srst, 1'b0);
    chk32(rdd, {16'h0000, 16'hBEEF});
    cpu.issue(8'hC1, 32'h0000_CAFE);
    chk1(bwr, 1'b1);
    chk32({bwd, hw}, 32'hCAFE_0000);
    cpu.issue(8'h41, 32'h0);
    chk1(brd & basy, 1'b1);
    chk32(rdd, 32'h0000_55AA);
    cpu.issue(8'hC0, 32'h0000_1357);
    chk1(bwr & !basy, 1'b1);
    chk32({16'h0000, bwd}, 32'h0000_1357);
    cpu.idle();
    evt = 32'h0000_0041;
    cevt = 16'h0040;
    @(negedge i_clk);
    evt = 32'h0000_0002;
    cevt = 16'h0000;
    // Bit 1 is cleared and raised in the same cycle, so the new event must win.
    cpu.issue(8'h83, 32'h0000_0003);
    chk32(est, 32'h0000_0042);
    chk32({16'h0000, cfl}, 32'h0000_0040);
    evt = 32'h0;
    cevt = 16'h0001;
    cpu.issue(8'hA4, 32'h0000_0040);
    cevt = 16'h0000;
    chk32({16'h0000, cfl}, 32'h0000_0001);
    // A hardware reset in mid-run clears what a software reset keeps.
    cpu.idle();
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    chk32(mode | {16'h0000, hw}, 32'h0);
    cpu.issue(8'h28, 32'h0);
    chk32(rdd, 32'h0);
    cpu.idle();
    tally_and_finish();
  end
endmodule // usb_host_register_map_test
`default_nettype wire
